/* File: common/adrs_pkg.sv */
// Shared constants for the converter result-ready serial port
package adrs_pkg;
    localparam int WORD_W = 24;
    localparam int CMD_W = 8;
    localparam int CNT_W = 5;
    // Command byte layout
    localparam int CMD_RD_BIT = 7;
    localparam int CMD_SEL_LSB = 0;
    localparam int CMD_SEL_W = 3;
    // Register selection codes
    localparam logic [2:0] SEL_COMMS = 3'h0;
    localparam logic [2:0] SEL_DATA = 3'h1;
    localparam logic [2:0] SEL_MODE = 3'h2;
    localparam logic [2:0] SEL_FILT = 3'h3;
    localparam logic [2:0] SEL_OFFS = 3'h4;
    localparam logic [2:0] SEL_GAIN = 3'h5;
    // Mode register fields
    localparam int MODE_CAL_BIT = 0;
    localparam int MODE_BIP_BIT = 1;
    // Status register fields
    localparam int STAT_RDY_BIT = 0;
    localparam int STAT_CAL_BIT = 1;
    localparam int STAT_BIP_BIT = 2;
    // Reset values
    localparam logic [23:0] MODE_RST = 24'h000000;
    localparam logic [23:0] FILT_RST = 24'h000000;
    localparam logic [23:0] OFFS_RST = 24'h000000;
    localparam logic [23:0] GAIN_RST = 24'h000000;
    localparam logic [7:0] CMD_RST = 8'h00;
    localparam logic [23:0] SIGN_FLIP = 24'h800000;
    // Timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int UPD_NS = 100;
    localparam int UPD_CYC = (UPD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FIFO_DEPTH = 16;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_READY = 4'h2,
        ST_UPDATE = 4'h4,
        ST_CAL = 4'h8
    } adrs_state_t;
endpackage

/* File: rtl/adrs_fifo.sv */
// Parameterised result FIFO with valid/ready on both sides
`timescale 1ns/100ps
module adrs_fifo #(
    parameter int W = 24,
    parameter int D = 16
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [W-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [W-1:0] outData
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wrPtr_r;
    logic [AW-1:0] rdPtr_r;
    logic [AW:0] count_r;
    logic push;
    logic pop;

    assign inReady = (count_r != (AW+1)'(D));
    assign outValid = (count_r != '0);
    assign outData = mem[rdPtr_r];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    always_ff @(posedge clock) begin
        if (push) begin
            mem[wrPtr_r] <= inData;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wrPtr_r <= (wrPtr_r == AW'(D-1)) ? '0 : wrPtr_r + 1'b1;
            end
            if (pop) begin
                rdPtr_r <= (rdPtr_r == AW'(D-1)) ? '0 : rdPtr_r + 1'b1;
            end
            count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    a_fifo_count: assert property (@(posedge clock) disable iff (rst)
        count_r <= (AW+1)'(D))
        else $error("fifo count beyond depth");
endmodule

/* File: rtl/adrs_serial_port.sv */
// Result-ready status and serial register port of the converter
`timescale 1ns/100ps
module adrs_serial_port #(
    parameter int DEPTH = adrs_pkg::FIFO_DEPTH
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic sclkPin,
    input wire logic csNPin,
    input wire logic dinPin,
    output logic doutPin,
    output logic rdyN,
    input wire logic resValid,
    output logic resReady,
    input wire logic [23:0] resData,
    output logic calStart,
    input wire logic calDone,
    input wire logic [23:0] calOffsIn,
    input wire logic [23:0] calGainIn
);
    localparam int W = adrs_pkg::WORD_W;
    logic [2:0] sclkSy_r;
    logic [1:0] csSy_r;
    logic [1:0] dinSy_r;
    logic sclkRise;
    logic sclkFall;
    logic csHigh;
    logic dinBit;
    logic phaseData_r;
    logic [adrs_pkg::CNT_W-1:0] bitCnt_r;
    logic [7:0] cmd_r;
    logic [W-1:0] inShift_r;
    logic [W-1:0] outShift_r;
    logic [7:0] cmdWord;
    logic [W-1:0] wrWord;
    logic [2:0] sel;
    logic rdCmd;
    logic cmdDone;
    logic wordDone;
    logic wrDone;
    logic readDone;
    logic reading;
    logic [W-1:0] modeReg_r;
    logic [W-1:0] filtReg_r;
    logic [W-1:0] offsReg_r;
    logic [W-1:0] gainReg_r;
    logic [W-1:0] dataReg_r;
    logic [W-1:0] status;
    logic [W-1:0] rdMux;
    logic calMode;
    logic bipolar;
    logic calKick;
    logic fifoValid;
    logic fifoPop;
    logic [W-1:0] fifoData;
    logic resLoad;
    logic [2:0] updCnt_r;
    adrs_pkg::adrs_state_t state_r;
    adrs_pkg::adrs_state_t state_nxt;

    // Pin synchronisers
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sclkSy_r <= 3'h7;
            csSy_r <= 2'h3;
            dinSy_r <= 2'h0;
        end else begin
            sclkSy_r <= {sclkSy_r[1:0], sclkPin};
            csSy_r <= {csSy_r[0], csNPin};
            dinSy_r <= {dinSy_r[0], dinPin};
        end
    end

    assign sclkRise = sclkSy_r[1] && !sclkSy_r[2];
    assign sclkFall = !sclkSy_r[1] && sclkSy_r[2];
    assign csHigh = csSy_r[1];
    assign dinBit = dinSy_r[1];

    assign cmdWord = {inShift_r[6:0], dinBit};
    assign wrWord = {inShift_r[W-2:0], dinBit};
    assign sel = cmd_r[adrs_pkg::CMD_SEL_LSB +: adrs_pkg::CMD_SEL_W];
    assign rdCmd = cmd_r[adrs_pkg::CMD_RD_BIT];
    assign cmdDone = sclkRise && !csHigh && !phaseData_r && (bitCnt_r == 5'h07);
    assign wordDone = sclkRise && !csHigh && phaseData_r && (bitCnt_r == 5'(W-1));
    assign wrDone = wordDone && !rdCmd;
    assign readDone = wordDone && rdCmd && (sel == adrs_pkg::SEL_DATA);
    assign reading = phaseData_r && rdCmd && (sel == adrs_pkg::SEL_DATA);

    assign calMode = modeReg_r[adrs_pkg::MODE_CAL_BIT];
    assign bipolar = modeReg_r[adrs_pkg::MODE_BIP_BIT];
    assign calKick = wrDone && (sel == adrs_pkg::SEL_MODE)
        && wrWord[adrs_pkg::MODE_CAL_BIT] && (state_r != adrs_pkg::ST_CAL);

    always_comb begin
        status = '0;
        status[adrs_pkg::STAT_RDY_BIT] = rdyN;
        status[adrs_pkg::STAT_CAL_BIT] = calMode;
        status[adrs_pkg::STAT_BIP_BIT] = bipolar;
    end

    // Output shifter source chosen by select field
    always_comb begin
        case (cmdWord[adrs_pkg::CMD_SEL_LSB +: adrs_pkg::CMD_SEL_W])
            adrs_pkg::SEL_DATA: rdMux = dataReg_r;
            adrs_pkg::SEL_MODE: rdMux = modeReg_r;
            adrs_pkg::SEL_FILT: rdMux = filtReg_r;
            adrs_pkg::SEL_OFFS: rdMux = offsReg_r;
            adrs_pkg::SEL_GAIN: rdMux = gainReg_r;
            default: rdMux = status;
        endcase
    end

    // Frame control; select high resets the frame, tied low runs three-wire
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            phaseData_r <= 1'b0;
            bitCnt_r <= '0;
            cmd_r <= adrs_pkg::CMD_RST;
            inShift_r <= '0;
        end else if (csHigh) begin
            phaseData_r <= 1'b0;
            bitCnt_r <= '0;
        end else if (sclkRise) begin
            inShift_r <= wrWord;
            if (cmdDone) begin
                cmd_r <= cmdWord;
                bitCnt_r <= '0;
                phaseData_r <= cmdWord[adrs_pkg::CMD_RD_BIT] ||
                    (cmdWord[adrs_pkg::CMD_SEL_LSB +: adrs_pkg::CMD_SEL_W]
                     != adrs_pkg::SEL_COMMS);
            end else if (wordDone) begin
                bitCnt_r <= '0;
                phaseData_r <= 1'b0;
            end else begin
                bitCnt_r <= bitCnt_r + 5'h01;
            end
        end
    end

    // Output shifter, MSB first, advances on falling clock
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            outShift_r <= '0;
        end else if (cmdDone && cmdWord[adrs_pkg::CMD_RD_BIT]) begin
            outShift_r <= rdMux;
        end else if (sclkFall && phaseData_r && rdCmd && !csHigh) begin
            outShift_r <= {outShift_r[W-2:0], 1'b0};
        end
    end

    assign doutPin = outShift_r[W-1];

    // Writable registers
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            modeReg_r <= adrs_pkg::MODE_RST;
            filtReg_r <= adrs_pkg::FILT_RST;
            offsReg_r <= adrs_pkg::OFFS_RST;
            gainReg_r <= adrs_pkg::GAIN_RST;
        end else begin
            if (wrDone && sel == adrs_pkg::SEL_MODE) begin
                modeReg_r <= wrWord;
            end else if (calDone && state_r == adrs_pkg::ST_CAL) begin
                modeReg_r[adrs_pkg::MODE_CAL_BIT] <= 1'b0;
            end
            if (wrDone && sel == adrs_pkg::SEL_FILT) begin
                filtReg_r <= wrWord;
            end
            if (wrDone && sel == adrs_pkg::SEL_OFFS) begin
                offsReg_r <= wrWord;
            end else if (calDone && state_r == adrs_pkg::ST_CAL) begin
                offsReg_r <= calOffsIn;
            end
            if (wrDone && sel == adrs_pkg::SEL_GAIN) begin
                gainReg_r <= wrWord;
            end else if (calDone && state_r == adrs_pkg::ST_CAL) begin
                gainReg_r <= calGainIn;
            end
        end
    end

    adrs_fifo #(
        .W(W),
        .D(DEPTH)
    ) u_fifo (
        .clock(clock),
        .rst(rst),
        .inValid(resValid),
        .inReady(resReady),
        .inData(resData),
        .outValid(fifoValid),
        .outReady(fifoPop),
        .outData(fifoData)
    );

    // Ready state machine
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            adrs_pkg::ST_IDLE: begin
                if (calKick) begin
                    state_nxt = adrs_pkg::ST_CAL;
                end else if (fifoValid && !calMode && !reading) begin
                    state_nxt = adrs_pkg::ST_UPDATE;
                end
            end
            adrs_pkg::ST_READY: begin
                if (calKick) begin
                    state_nxt = adrs_pkg::ST_CAL;
                end else if (readDone) begin
                    state_nxt = adrs_pkg::ST_IDLE;
                end else if (fifoValid && !calMode && !reading) begin
                    state_nxt = adrs_pkg::ST_UPDATE;
                end
            end
            adrs_pkg::ST_UPDATE: begin
                if (calKick) begin
                    state_nxt = adrs_pkg::ST_CAL;
                end else if (updCnt_r == 3'h0) begin
                    state_nxt = adrs_pkg::ST_READY;
                end
            end
            adrs_pkg::ST_CAL: begin
                if (calDone) begin
                    state_nxt = adrs_pkg::ST_READY;
                end
            end
            default: state_nxt = adrs_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_r <= adrs_pkg::ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            updCnt_r <= '0;
        end else if (state_nxt == adrs_pkg::ST_UPDATE && state_r != adrs_pkg::ST_UPDATE) begin
            updCnt_r <= 3'(adrs_pkg::UPD_CYC - 1);
        end else if (updCnt_r != 3'h0) begin
            updCnt_r <= updCnt_r - 3'h1;
        end
    end

    assign resLoad = (state_r == adrs_pkg::ST_UPDATE) && (updCnt_r == 3'h0) && !calKick;
    assign fifoPop = resLoad;

    // Result register; bipolar flips sign bit to offset binary
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            dataReg_r <= '0;
        end else if (resLoad) begin
            dataReg_r <= bipolar ? (fifoData ^ adrs_pkg::SIGN_FLIP) : fifoData;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            calStart <= 1'b0;
        end else begin
            calStart <= calKick;
        end
    end

    assign rdyN = (state_r != adrs_pkg::ST_READY);

    a_load_drops_ready: assert property (@(posedge clock) disable iff (rst)
        resLoad |=> !rdyN)
        else $error("ready not low after result load");
    a_read_raises_ready: assert property (@(posedge clock) disable iff (rst)
        (readDone && !calKick) |=> rdyN)
        else $error("ready not high after result read");
    a_update_window: assert property (@(posedge clock) disable iff (rst)
        (state_r == adrs_pkg::ST_READY && state_nxt == adrs_pkg::ST_UPDATE)
        |=> (rdyN && !calKick)[*4] ##1 !rdyN)
        else $error("update window length wrong");
    a_cal_ready_high: assert property (@(posedge clock) disable iff (rst)
        calKick |=> rdyN && calStart && state_r == adrs_pkg::ST_CAL)
        else $error("ready not high at calibration start");
    a_cal_done_low: assert property (@(posedge clock) disable iff (rst)
        (state_r == adrs_pkg::ST_CAL && calDone) |=> !rdyN && !calMode)
        else $error("ready not low at calibration end");
    a_out_load_sel: assert property (@(posedge clock) disable iff (rst)
        (cmdDone && cmdWord == 8'h81) |=> outShift_r == $past(dataReg_r))
        else $error("output shifter not loaded from result");
    a_mode_write: assert property (@(posedge clock) disable iff (rst)
        (wrDone && sel == adrs_pkg::SEL_MODE) |=> modeReg_r == $past(wrWord))
        else $error("mode register write lost");
    a_offset_binary: assert property (@(posedge clock) disable iff (rst)
        (resLoad && bipolar) |=> dataReg_r == ($past(fifoData) ^ 24'h800000))
        else $error("bipolar result not offset binary");
    a_select_resets: assert property (@(posedge clock) disable iff (rst)
        csHigh |=> bitCnt_r == '0 && !phaseData_r)
        else $error("frame not reset by select");
    a_msb_first: assert property (@(posedge clock) disable iff (rst)
        (sclkFall && phaseData_r && rdCmd && !csHigh && !cmdDone)
        |=> outShift_r == {$past(outShift_r[W-2:0]), 1'b0})
        else $error("output not shifted msb first");
endmodule

/* File: verification/adrs_host_model.sv */
// Host-side serial master model for the result-ready serial port
`timescale 1ns/100ps
module adrs_host_model #(
    parameter int HALF = 6
) (
    input wire logic clock,
    output logic sclkPin,
    output logic csNPin,
    output logic dinPin,
    input wire logic doutPin,
    input wire logic rdyN
);
    int halfCyc = HALF;

    initial begin
        sclkPin = 1'b1;
        csNPin = 1'b1;
        dinPin = 1'b0;
    end

    // Half serial period in system cycles
    task automatic half();
        repeat (halfCyc) @(negedge clock);
    endtask

    // Command byte, then nData data bits, MSB first
    task automatic xfer(input logic [7:0] cmd, input logic [23:0] wd, input int nData,
                        input bit hold, output logic [23:0] rd);
        rd = '0;
        csNPin = 1'b0;
        half();
        for (int i = 31; i >= 24 - nData; i--) begin
            if (i < 24) begin
                rd[i] = doutPin;
            end
            sclkPin = 1'b0;
            dinPin = (i >= 24) ? cmd[i-24] : wd[i];
            half();
            sclkPin = 1'b1;
            half();
        end
        dinPin = ~dinPin;
        if (!hold) begin
            csNPin = 1'b1;
        end
        half();
    endtask

    // Result reads wait up to 400 cycles for a fresh word to be flagged, then start regardless
    task automatic waitReady(output bit ok);
        ok = 1'b0;
        for (int k = 0; k < 400 && !ok; k++) begin
            @(negedge clock);
            ok = (rdyN === 1'b0);
        end
    endtask
endmodule

/* File: verification/adrs_serial_port_test.sv */
// Self-checking testbench of the result-ready serial port
`timescale 1ns/100ps
module adrs_serial_port_test;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic sclkPin, csNPin, dinPin, doutPin, rdyN, resReady, calStart;
    logic resValid = 1'b0;
    logic calDone = 1'b0;
    logic [23:0] resData = '0;
    logic [23:0] calOffsIn = '0;
    logic [23:0] calGainIn = '0;
    logic [31:0] seed = 32'h1e5d;
    int errTotal = 0;
    int samplesChecked = 0;
    int calPulses = 0;
    int highRun = 0;
    int lastHigh = 0;

    always #12.5 clock = ~clock;

    adrs_serial_port #(.DEPTH(adrs_pkg::FIFO_DEPTH)) dut_u (
        .clock(clock), .rst(rst), .sclkPin(sclkPin), .csNPin(csNPin), .dinPin(dinPin),
        .doutPin(doutPin), .rdyN(rdyN), .resValid(resValid), .resReady(resReady),
        .resData(resData), .calStart(calStart), .calDone(calDone),
        .calOffsIn(calOffsIn), .calGainIn(calGainIn)
    );

    adrs_host_model host_u (
        .clock(clock), .sclkPin(sclkPin), .csNPin(csNPin), .dinPin(dinPin),
        .doutPin(doutPin), .rdyN(rdyN)
    );

    // Calibration pulses and length of each ready-high run
    always @(posedge clock) begin
        if (calStart === 1'b1) begin
            calPulses++;
        end
        if (rdyN === 1'b1) begin
            highRun++;
        end else if (highRun != 0) begin
            lastHigh = highRun;
            highRun = 0;
        end
    end

    function automatic logic [23:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[23:0];
    endfunction

    // Offset binary flips the MSB of the raw result
    function automatic logic [23:0] expRes(input logic [23:0] raw, input logic bip);
        return bip ? (raw ^ 24'h800000) : raw;
    endfunction

    task automatic reportAndStop();
        if (errTotal == 0 && samplesChecked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [23:0] exp, input logic [23:0] got);
        samplesChecked++;
        if (got !== exp) begin
            errTotal++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic push(input logic [23:0] d);
        @(negedge clock);
        resValid = 1'b1;
        resData = d;
        for (int k = 0; k < 50 && resReady !== 1'b1; k++) @(negedge clock);
        @(negedge clock);
        resValid = 1'b0;
    endtask

    task automatic readRes(output logic [23:0] v);
        bit ok;
        host_u.waitReady(ok);
        check("rdyN low", 24'h1, {23'h0, ok});
        host_u.xfer(8'h81, '0, 24, 1'b0, v);
    endtask

    initial begin
        repeat (60000) @(posedge clock);
        errTotal++;
        reportAndStop();
    end

    initial begin
        logic [23:0] v, got, last;
        int n;
        bit ok;
        repeat (4) @(posedge clock);
        @(negedge clock);
        rst = 1'b0;
        repeat (3) @(negedge clock);
        check("rdyN idle", 24'h1, {23'h0, rdyN});
        for (int s = 3; s <= 5; s++) begin
            v = rnd();
            host_u.xfer(8'(s), v, 24, 1'b1, got);
            host_u.xfer(8'h80 | 8'(s), '0, 24, s != 5, got);
            check("reg readback", v, got);
        end
        host_u.xfer(8'h02, 24'h000002, 24, 1'b0, got);
        host_u.xfer(8'h80, '0, 24, 1'b0, got);
        check("status", 24'h000005, got);
        for (int i = 0; i < 6; i++) begin
            host_u.halfCyc = 5 + 4 * (i % 2);
            v = (i < 2) ? 24'h7fffff : (i < 4) ? 24'h800000 : rnd();
            host_u.xfer(8'h02, {22'h0, i[0], 1'b0}, 24, 1'b0, got);
            push(v);
            readRes(got);
            check("result", expRes(v, i[0]), got);
            check("rdyN after read", 24'h1, {23'h0, rdyN});
        end
        host_u.halfCyc = 6;
        push(rnd());
        host_u.waitReady(ok);
        host_u.xfer(8'h81, '0, 10, 1'b0, got);
        check("rdyN after abort", 24'h0, {23'h0, rdyN});
        last = rnd();
        push(last);
        for (int k = 0; k < 20 && rdyN !== 1'b1; k++) @(negedge clock);
        readRes(got);
        check("update span", 24'(adrs_pkg::UPD_CYC), 24'(lastHigh));
        check("newer result", expRes(last, 1'b1), got);
        host_u.xfer(8'h02, 24'h000003, 24, 1'b0, got);
        repeat (3) @(negedge clock);
        check("cal start", 24'h1, 24'(calPulses));
        check("rdyN in cal", 24'h1, {23'h0, rdyN});
        n = 0;
        resValid = 1'b1;
        for (int k = 0; k < 40; k++) begin
            resData = rnd();
            if (resReady !== 1'b1) break;
            last = resData;
            n++;
            @(negedge clock);
        end
        resValid = 1'b0;
        check("fifo depth", 24'h10, 24'(n));
        calOffsIn = rnd();
        calGainIn = rnd();
        calDone = 1'b1;
        @(negedge clock);
        calDone = 1'b0;
        host_u.waitReady(ok);
        check("cal done", 24'h1, {23'h0, ok});
        repeat (200) @(negedge clock);
        check("drained", 24'h1, {23'h0, resReady});
        readRes(got);
        check("last result", expRes(last, 1'b1), got);
        host_u.xfer(8'h84, '0, 24, 1'b0, got);
        check("offset cal", calOffsIn, got);
        host_u.xfer(8'h85, '0, 24, 1'b0, got);
        check("gain cal", calGainIn, got);
        host_u.xfer(8'h82, '0, 24, 1'b0, got);
        check("mode after cal", 24'h000002, got);
        reportAndStop();
    end
endmodule
